// File: xfer_ctl_regs.svh
// Offsets, field positions and constants of the event transfer controller
`ifndef XFER_CTL_REGS_SVH
`define XFER_CTL_REGS_SVH
`define CSR_OFS      12'h000
`define BASE_OFS     12'h004
`define EN_FIRST_OFS 12'h008
`define EN_LAST_OFS  12'h01C
`define EN_COUNT     6
`define CSR_RESET    16'h0000
`define BASE_RESET   16'h0000
`define EN_RESET     8'h00
`define CSR_SWEN     15
`define CSR_BUSY     14
`define CSR_NMIF     13
`define CSR_VEC      7:0
`define F_SM         15:14
`define F_DM         13:12
`define F_MD         11:10
`define F_SZ         9:8
`define F_DTS        7
`define F_CHAIN_ENABLE       6
`define F_PER_TRANSFER_IRQ_SELECT      5
`define F_NONMASKABLE_SUSPEND_MODE       4
`define STEP_INC     2'h2
`define STEP_DEC     2'h3
`define MD_NORMAL    2'h0
`define MD_REPEAT    2'h1
`define MD_BLOCK     2'h2
`define SZ_BYTE      2'h0
`define SZ_WORD      2'h1
`define SZ_LONG      2'h2
`define VEC_TABLE    32'h0000_0400
`define DESC_STRIDE  32'h0000_0010
`define DESC_LAST    2'h3
`endif

// File: xfer_ctl_pkg.sv
// Types shared by the event transfer controller
package xfer_ctl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_VEC, ST_FETCH, ST_RD, ST_WR, ST_WB
   } state_t;
endpackage : xfer_ctl_pkg

// File: event_transfer_controller.sv
// Event-triggered memory-to-memory transfer controller with APB registers
`timescale 1ns/1ps
`include "xfer_ctl_regs.svh"
module event_transfer_controller (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [47:0] irq_src,
   input  wire logic        nmi,
   output logic             mem_req,
   output logic             mem_we,
   output logic      [31:0] mem_addr,
   output logic      [1:0]  mem_size,
   output logic      [31:0] mem_wdata,
   input  wire logic        mem_ack,
   input  wire logic [31:0] mem_rdata,
   output logic             cpu_irq,
   output logic      [7:0]  cpu_irq_vec
);
   xfer_ctl_pkg::state_t state, next_state;
   logic [15:0] base_upper;
   logic [47:0] en, pending;
   logic        sw_en, sw_pend, nmi_flag;
   logic [7:0]  sw_vec, vec;
   logic        vec_hw, stop;
   logic [1:0]  ph;
   logic [15:0] mode, cnt_a, blk_left;
   logic [31:0] iar, sar, dar, rf, blk_base, data_buf;
   localparam logic [15:0] csr_rst = `CSR_RESET;

   // APB decode; registers answer with no wait state
   wire         acc      = psel & penable;
   wire         wr       = acc & pwrite;
   wire         csr_hit  = paddr == `CSR_OFS;
   wire         base_hit = paddr == `BASE_OFS;
   wire         en_hit   = paddr >= `EN_FIRST_OFS && paddr <= `EN_LAST_OFS
                           && paddr[1:0] == 2'h0;
   wire [11:0]  en_rel   = paddr - `EN_FIRST_OFS;
   wire [2:0]   en_idx   = en_rel[4:2];
   wire         hit      = csr_hit | base_hit | en_hit;
   wire         base_wr  = wr & base_hit & (pstrb[1:0] == 2'h3);
   wire [15:0]  csr_rd   = {sw_en, state != xfer_ctl_pkg::ST_IDLE, nmi_flag,
                            5'h00, sw_vec};
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;
   assign prdata  = csr_hit  ? {16'h0000, csr_rd} :
                    base_hit ? {16'h0000, base_upper} :
                    en_hit   ? {24'h000000, en[en_idx*8 +: 8]} : 32'h0000_0000;

   // Lowest numbered enabled pending source wins
   logic [5:0] sel;
   logic       hw_any;
   always_comb begin
      sel    = 6'h00;
      hw_any = 1'b0;
      for (int i = 47; i >= 0; i--) begin
         if (pending[i]) begin
            sel    = 6'(i);
            hw_any = 1'b1;
         end
      end
   end
   wire any_req = hw_any | sw_pend;

   // Mode word fields
   wire [1:0] sm   = mode[`F_SM];
   wire [1:0] dm   = mode[`F_DM];
   wire [1:0] md   = mode[`F_MD];
   wire [1:0] sz   = mode[`F_SZ];
   wire       repeat_side_select  = mode[`F_DTS];
   wire       chain_enable = mode[`F_CHAIN_ENABLE];
   wire       per_transfer_irq_select = mode[`F_PER_TRANSFER_IRQ_SELECT];
   wire       nonmaskable_suspend_mode = mode[`F_NONMASKABLE_SUSPEND_MODE];
   wire [31:0] step = sz == `SZ_LONG ? 32'h0000_0004 :
                      sz == `SZ_WORD ? 32'h0000_0002 : 32'h0000_0001;
   wire [31:0] sar_step = sm == `STEP_INC ? sar + step :
                          sm == `STEP_DEC ? sar - step : sar;
   wire [31:0] dar_step = dm == `STEP_INC ? dar + step :
                          dm == `STEP_DEC ? dar - step : dar;

   wire ack       = mem_req & mem_ack;
   wire vec_done  = state == xfer_ctl_pkg::ST_VEC & mem_ack;
   wire fetch_done = state == xfer_ctl_pkg::ST_FETCH & mem_ack
                     & ph == `DESC_LAST;
   wire wr_done   = state == xfer_ctl_pkg::ST_WR & mem_ack;
   wire wb_done   = state == xfer_ctl_pkg::ST_WB & mem_ack & ph == `DESC_LAST;
   wire blk_more  = md == `MD_BLOCK && blk_left != 16'h0001;
   wire unit_done = wr_done & ~blk_more;
   wire [15:0] cnt_dec = cnt_a - 16'h0001;
   wire [7:0]  rpt_dec = cnt_a[7:0] - 8'h01;
   // Zero count ends normal and block sequences
   wire seq_end = md != `MD_REPEAT && cnt_a == 16'h0000;
   // Stop point at start or block step
   wire nmi_stop = nmi & ~nonmaskable_suspend_mode;
   wire [15:0] vec_lo = mem_rdata[15:0];

   always_comb begin
      next_state = state;
      case (state)
         xfer_ctl_pkg::ST_IDLE:
            if (any_req)
               next_state = xfer_ctl_pkg::ST_VEC;
         xfer_ctl_pkg::ST_VEC:
            if (mem_ack)
               next_state = xfer_ctl_pkg::ST_FETCH;
         xfer_ctl_pkg::ST_FETCH:
            if (fetch_done)
               next_state = nmi_stop ? xfer_ctl_pkg::ST_WB
                                     : xfer_ctl_pkg::ST_RD;
         xfer_ctl_pkg::ST_RD:
            if (mem_ack)
               next_state = xfer_ctl_pkg::ST_WR;
         xfer_ctl_pkg::ST_WR:
            if (mem_ack)
               next_state = blk_more & ~nmi_stop ? xfer_ctl_pkg::ST_RD
                                                 : xfer_ctl_pkg::ST_WB;
         xfer_ctl_pkg::ST_WB:
            if (wb_done)
               next_state = chain_enable & ~stop ? xfer_ctl_pkg::ST_FETCH
                                         : xfer_ctl_pkg::ST_IDLE;
         default:
            next_state = xfer_ctl_pkg::ST_IDLE;
      endcase
   end

   // Memory master port
   logic [31:0] wb_word;
   always_comb begin
      case (ph)
         2'h0:    wb_word = {mode, cnt_a};
         2'h1:    wb_word = iar;
         2'h2:    wb_word = sar;
         default: wb_word = dar;
      endcase
   end
   assign mem_req  = state != xfer_ctl_pkg::ST_IDLE;
   assign mem_we   = state == xfer_ctl_pkg::ST_WR | state == xfer_ctl_pkg::ST_WB;
   assign mem_size = state == xfer_ctl_pkg::ST_RD |
                     state == xfer_ctl_pkg::ST_WR ? sz : `SZ_LONG;
   assign mem_wdata = state == xfer_ctl_pkg::ST_WB ? wb_word : data_buf;
   always_comb begin
      case (state)
         xfer_ctl_pkg::ST_VEC:   mem_addr = `VEC_TABLE + {22'h0, vec, 2'h0};
         xfer_ctl_pkg::ST_RD:    mem_addr = sar;
         xfer_ctl_pkg::ST_WR:    mem_addr = dar;
         xfer_ctl_pkg::ST_FETCH: mem_addr = rf + {28'h0, ph, 2'h0};
         xfer_ctl_pkg::ST_WB:    mem_addr = rf + {28'h0, ph, 2'h0};
         default:                mem_addr = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn)
         state <= xfer_ctl_pkg::ST_IDLE;
      else
         state <= next_state;
   end

   // Registers reachable from software plus the pending flags; event set wins over service clear
   wire         take    = state == xfer_ctl_pkg::ST_IDLE & any_req;
   wire [47:0]  served  = take & hw_any ? 48'h1 << sel : 48'h0;
   wire [47:0]  done_clr = wb_done & seq_end & vec_hw & ~stop ?
                           48'h1 << vec[5:0] : 48'h0;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         en         <= {`EN_COUNT{`EN_RESET}};
         pending    <= 48'h0;
         base_upper <= `BASE_RESET;
         {sw_en, sw_vec} <= {csr_rst[`CSR_SWEN], csr_rst[`CSR_VEC]};
         sw_pend    <= 1'b0;
         nmi_flag   <= 1'b0;
      end else begin
         // Six byte-wide enable registers
         // Sequence-end clear survives a write to another enable byte
         en <= en & ~done_clr;
         if (wr & en_hit)
            en[en_idx*8 +: 8] <= pwdata[7:0];
         pending <= (pending & ~served) | (irq_src & en);
         if (base_wr)
            base_upper <= pwdata[15:0];
         if (wr & csr_hit) begin
            sw_en  <= pwdata[`CSR_SWEN];
            sw_vec <= pwdata[`CSR_VEC];
         end
         sw_pend <= wr & csr_hit & pwdata[`CSR_SWEN] |
                    sw_pend & ~(take & ~hw_any);
         nmi_flag <= wb_done & stop |
                     nmi_flag & ~(wr & csr_hit & pwdata[`CSR_NMIF]);
      end
   end

   // Descriptor copy lives only inside the engine
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         vec <= 8'h00;
         vec_hw <= 1'b0;
         ph <= 2'h0;
         rf <= 32'h0;
         stop <= 1'b0;
         data_buf <= 32'h0;
      end else begin
         if (take) begin
            vec    <= hw_any ? {2'h0, sel} : sw_vec;
            vec_hw <= hw_any;
            stop   <= 1'b0;
         end
         // Descriptor address from vector and base
         if (vec_done)
            rf <= {base_upper, vec_lo};
         else if (wb_done)
            rf <= rf + `DESC_STRIDE;
         if ((state == xfer_ctl_pkg::ST_FETCH |
              state == xfer_ctl_pkg::ST_WB) & mem_ack)
            ph <= ph + 2'h1;
         if (fetch_done | wr_done & blk_more)
            stop <= nmi_stop;
         if (state == xfer_ctl_pkg::ST_RD & mem_ack)
            data_buf <= mem_rdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         {mode, cnt_a, iar, sar, dar} <= 128'h0;
         {blk_left, blk_base} <= 48'h0;
      end else if (state == xfer_ctl_pkg::ST_FETCH & mem_ack) begin
         case (ph)
            2'h0: {mode, cnt_a} <= mem_rdata;
            2'h1: iar <= mem_rdata;
            2'h2: sar <= mem_rdata;
            default: begin
               dar <= mem_rdata;
               blk_left <= iar[15:0];
               // Block area chosen by side bit
               blk_base <= repeat_side_select ? sar : mem_rdata;
            end
         endcase
      end else if (wr_done) begin
         sar <= sar_step;
         dar <= dar_step;
         blk_left <= blk_left - 16'h0001;
         if (unit_done) begin
            case (md)
               `MD_REPEAT: begin
                  cnt_a[7:0] <= rpt_dec == 8'h00 ? cnt_a[15:8] : rpt_dec;
                  if (rpt_dec == 8'h00 && repeat_side_select)
                     sar <= iar;
                  if (rpt_dec == 8'h00 && !repeat_side_select)
                     dar <= iar;
               end
               `MD_BLOCK: begin
                  cnt_a <= cnt_dec;
                  blk_left <= iar[15:0];
                  if (repeat_side_select)
                     sar <= blk_base;
                  else
                     dar <= blk_base;
               end
               default: cnt_a <= cnt_dec;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cpu_irq <= 1'b0;
         cpu_irq_vec <= 8'h00;
      end else begin
         cpu_irq <= wb_done & ~stop & (per_transfer_irq_select | seq_end);
         if (wb_done)
            cpu_irq_vec <= vec;
      end
   end

   property p_start;
      @(posedge ref_clk) disable iff (!rstn)
      state == xfer_ctl_pkg::ST_IDLE && any_req |=>
         state == xfer_ctl_pkg::ST_VEC;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_every;
      @(posedge ref_clk) disable iff (!rstn)
      wb_done && per_transfer_irq_select && !stop |=> cpu_irq;
   endproperty
   a_every: assert property (p_every) else $error("irq missing");
   property p_endonly;
      @(posedge ref_clk) disable iff (!rstn)
      wb_done && !per_transfer_irq_select && !seq_end |=> !cpu_irq;
   endproperty
   a_endonly: assert property (p_endonly) else $error("early irq");
   property p_nochain;
      @(posedge ref_clk) disable iff (!rstn)
      wb_done && !chain_enable |=> state == xfer_ctl_pkg::ST_IDLE;
   endproperty
   a_nochain: assert property (p_nochain) else $error("chained");
   property p_nmi;
      @(posedge ref_clk) disable iff (!rstn)
      fetch_done && nmi && !nonmaskable_suspend_mode |=> state == xfer_ctl_pkg::ST_WB ##0 stop;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not stopped");
   property p_inc;
      @(posedge ref_clk) disable iff (!rstn)
      wr_done && md == `MD_NORMAL && sm == `STEP_INC |=>
         sar == $past(sar) + $past(step);
   endproperty
   a_inc: assert property (p_inc) else $error("source not stepped");
   property p_count;
      @(posedge ref_clk) disable iff (!rstn)
      unit_done && md == `MD_NORMAL |=> cnt_a == $past(cnt_a) - 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("count wrong");
   property p_reload;
      @(posedge ref_clk) disable iff (!rstn)
      unit_done && md == `MD_REPEAT && cnt_a[7:0] == 8'h01 |=>
         cnt_a[7:0] == cnt_a[15:8];
   endproperty
   a_reload: assert property (p_reload) else $error("no reload");
   property p_base;
      @(posedge ref_clk) disable iff (!rstn)
      vec_done |=> mem_addr == {base_upper, $past(vec_lo)};
   endproperty
   a_base: assert property (p_base) else $error("bad descriptor addr");
   property p_unmapped;
      @(posedge ref_clk) disable iff (!rstn)
      acc && !hit |-> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("no error");
   property p_restore;
      @(posedge ref_clk) disable iff (!rstn)
      unit_done && md == `MD_REPEAT && rpt_dec == 8'h00 && repeat_side_select |=>
         sar == $past(iar);
   endproperty
   a_restore: assert property (p_restore) else $error("no restore");
   property p_blkarea;
      @(posedge ref_clk) disable iff (!rstn)
      unit_done && md == `MD_BLOCK && !repeat_side_select |=> dar == $past(blk_base);
   endproperty
   a_blkarea: assert property (p_blkarea) else $error("block area");
   property p_basewr;
      @(posedge ref_clk) disable iff (!rstn)
      base_wr |=> base_upper == $past(pwdata[15:0]);
   endproperty
   a_basewr: assert property (p_basewr) else $error("base write");
   property p_pend;
      @(posedge ref_clk) disable iff (!rstn)
      |(irq_src & en) |=>
         (pending & $past(irq_src & en)) == $past(irq_src & en);
   endproperty
   a_pend: assert property (p_pend) else $error("event lost");
   property p_pulse;
      @(posedge ref_clk) disable iff (!rstn)
      cpu_irq |=> !cpu_irq;
   endproperty
   a_pulse: assert property (p_pulse) else $error("irq not a pulse");
endmodule : event_transfer_controller

// File: ram_responder.sv
// On-chip RAM model that answers the controller's memory port
`timescale 1ns/1ps
module ram_responder (
   input  wire logic        ref_clk,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [1:0]  mem_size,
   input  wire logic [31:0] mem_wdata,
   input  wire logic [3:0]  lat,
   output logic             mem_ack,
   output logic      [31:0] mem_rdata
);
   logic [7:0]  m [0:4095];
   logic [3:0]  wait_cnt = 4'h0;
   wire  [11:0] a = mem_addr[11:0];
   wire  [2:0]  nb = (mem_size == 2'h2) ? 3'h4 :
                     (mem_size == 2'h1) ? 3'h2 : 3'h1;
   initial mem_ack = 1'b0;
   initial mem_rdata = 32'h0000_0000;
   // Data lines keep changing outside ack cycles, never hold old data
   always @(posedge ref_clk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      // The !mem_ack term stops one request from being answered twice
      if (mem_req && !mem_ack) begin
         if (wait_cnt < lat) begin
            wait_cnt <= wait_cnt + 4'h1;
         end else begin
            wait_cnt <= 4'h0;
            mem_ack <= 1'b1;
            mem_rdata <= {m[a + 12'h3], m[a + 12'h2], m[a + 12'h1], m[a]};
            for (int i = 0; i < 4; i++) begin
               if (mem_we && i < nb) begin
                  m[a + 12'(i)] <= mem_wdata[8*i +: 8];
               end
            end
         end
      end
   end
endmodule : ram_responder

// File: event_triggered_transfer_controller_tb_top.sv
// Self-checking bench for the event transfer controller
`timescale 1ns/1ps
module event_triggered_transfer_controller_tb_top;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0]  pstrb = 4'hF;
   logic [47:0] irq_src = 48'h0;
   logic        nmi = 1'b0;
   logic [3:0]  lat = 4'h0;
   logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, rd;
   logic [1:0]  mem_size;
   logic [7:0]  cpu_irq_vec;
   logic        pready, pslverr, mem_req, mem_we, mem_ack, cpu_irq, err;
   int          fail_count = 0;
   int          n_compared = 0;
   int          irqs;
   logic [7:0]  irq_vec;
   always #4 ref_clk = ~ref_clk;
   event_transfer_controller i_event_transfer_controller (
      .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_src(irq_src), .nmi(nmi), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .cpu_irq(cpu_irq),
      .cpu_irq_vec(cpu_irq_vec));
   ram_responder i_ram_responder (
      .ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
      .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got,
                  exp);
      end
   endtask : chk
   task automatic conclude();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // pready is always high, so this wait ends after one cycle
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic put32(input int a, input logic [31:0] v);
      for (int i = 0; i < 4; i++) i_ram_responder.m[a + i] = v[8*i +: 8];
   endtask : put32
   function automatic logic [31:0] get32(input int a);
      return {i_ram_responder.m[a + 3], i_ram_responder.m[a + 2],
              i_ram_responder.m[a + 1], i_ram_responder.m[a]};
   endfunction : get32
   task automatic desc(input int rf, input logic [15:0] mode, cnta,
                       input logic [31:0] w1, src, dst);
      put32(rf, {mode, cnta});
      put32(rf + 4, w1);
      put32(rf + 8, src);
      put32(rf + 12, dst);
   endtask : desc
   // Fires source s, or a software start with vector s; counts interrupts
   task automatic go(input int s, input logic sw);
      int n;
      irqs = 0;
      n = 0;
      if (sw) begin
         apb(1'b1, 12'h000, 32'h0000_8000 | 32'(s));
      end else begin
         @(posedge ref_clk);
         irq_src[s] <= 1'b1;
         @(posedge ref_clk);
         irq_src[s] <= 1'b0;
      end
      while (mem_req !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      chk(mem_req, 1'b1, "no activation");
      while (n < 2000) begin
         @(posedge ref_clk);
         n++;
         if (cpu_irq === 1'b1) begin
            irqs++;
            irq_vec = cpu_irq_vec;
         end
         if (mem_req !== 1'b1) break;
      end
      chk(mem_req, 1'b0, "engine hung");
      repeat (3) begin
         @(posedge ref_clk);
         if (cpu_irq === 1'b1) begin
            irqs++;
            irq_vec = cpu_irq_vec;
         end
      end
   endtask : go
   task automatic t_regs();
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0, "status reset");
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 12'h008 + 12'(4*i), 32'(8'h11 * 8'(i + 1)));
         apb(1'b0, 12'h008 + 12'(4*i), 32'h0);
         chk(rd, 32'(8'h11 * 8'(i + 1)), "enable reg");
         apb(1'b1, 12'h008 + 12'(4*i), 32'h0);
      end
      apb(1'b1, 12'h004, 32'h1234);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h1234, "base reg");
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({rd[30:0], err}, 32'h1, "no descriptor access");
   endtask : t_regs
   task automatic t_repeat();
      desc(256, 16'h84A0, 16'h0303, 32'h200, 32'h200, 32'h300);
      put32(1044, 32'h100);
      put32(512, 32'h0043_4241);
      apb(1'b1, 12'h008, 32'h20);
      for (int k = 0; k < 4; k++) begin
         go(5, 1'b0);
         chk(irqs, 1, "per-transfer irq");
         chk(irq_vec, 32'h5, "irq vector");
         chk(get32(768), 32'h41 + k % 3, "repeat data");
         chk(get32(256), {16'h84A0, 8'h03, 8'(3 - (k + 1) % 3)},
             "count A");
         chk(get32(264), 32'h200 + (k + 1) % 3, "source");
         chk(get32(268), 32'h300, "dest fixed");
      end
   endtask : t_repeat
   task automatic t_block();
      for (int i = 0; i < 12; i++) i_ram_responder.m[512 + i] = 8'(16 + i);
      desc(320, 16'hA800, 16'h0003, 32'h4, 32'h200, 32'h300);
      desc(336, 16'h0000, 16'h0001, 32'h0, 32'h200, 32'h3F0);
      put32(1076, 32'h140);
      apb(1'b1, 12'h00C, 32'h20);
      lat <= 4'h3;
      for (int k = 0; k < 3; k++) begin
         go(13, 1'b0);
         chk(irqs, k == 2, "irq only at end");
         chk(get32(768), {8'(19 + 4*k), 8'(18 + 4*k), 8'(17 + 4*k),
             8'(16 + 4*k)}, "block data");
      end
      chk(irq_vec, 32'hD, "block irq vector");
      chk(get32(320), 32'hA800_0000, "block count");
      chk(get32(328), 32'h20C, "block source");
      chk(get32(332), 32'h300, "block dest");
      chk(get32(1008), 32'h0, "no chain");
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h0, "enable cleared");
   endtask : t_block
   task automatic t_nmi();
      desc(256, 16'h8000, 16'h0001, 32'h0, 32'h200, 32'h380);
      nmi <= 1'b1;
      go(5, 1'b0);
      nmi <= 1'b0;
      chk(get32(896), 32'h0, "nmi stop data");
      chk(irqs, 0, "nmi stop irq");
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[13], 1'b1, "stop flag");
      apb(1'b1, 12'h000, 32'h2000);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[13], 1'b0, "flag clear");
   endtask : t_nmi
   task automatic t_soft();
      desc(384, 16'hA100, 16'h0002, 32'h0, 32'h200, 32'h3A0);
      put32(1152, 32'h180);
      // One start moves one word in normal mode
      go(32, 1'b1);
      chk(irqs, 0, "early irq");
      chk(get32(384), 32'hA100_0001, "word count left");
      go(32, 1'b1);
      chk(get32(928), 32'h1312_1110, "word data");
      chk(irqs, 1, "end irq");
      chk(irq_vec, 32'h20, "soft vector");
      chk(get32(384), 32'hA100_0000, "word count");
      chk(get32(392), 32'h204, "word source");
   endtask : t_soft
   task automatic t_chain();
      // Longword source on a multiple of four
      desc(448, 16'hE240, 16'h0001, 32'h0, 32'h208, 32'h3B0);
      desc(464, 16'h8000, 16'h0001, 32'h0, 32'h200, 32'h3B8);
      put32(1156, 32'h1C0);
      go(33, 1'b1);
      chk(get32(944), 32'h1B1A_1918, "long data");
      chk(get32(456), 32'h204, "source stepped down");
      chk(get32(952), 32'h10, "chained data");
      chk(get32(464), 32'h8000_0000, "chained count");
   endtask : t_chain
   initial begin
      for (int i = 0; i < 4096; i++) i_ram_responder.m[i] = 8'h00;
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_repeat();
      t_block();
      t_nmi();
      t_soft();
      t_chain();
      conclude();
   end
   // Whole run needs under a thousand cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge ref_clk);
      chk(32'h0, 32'h1, "watchdog expired");
      conclude();
   end
endmodule : event_triggered_transfer_controller_tb_top
